// >>> plc_config_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// - slew field resets to 10h; only bit 0 acts, 0 fast, 1 slow.
// - snapshot bits 10:0 show each sampled strap level, 1 for high.
// - in common-pinout mode bit 14 drives MAC isolation; 1 isolates.
// - in RMII, bit 12 picks receive-valid meaning: 0 carrier-valid, 1 data-valid.
// - fast link-down strap loads 5b00000 when clear, 5b11010 when set.
// - bit 7 is inverse of crossover-disable strap, resets to 1.
// - bit 4 selects MAC interface: 0 MII, 1 RMII.
// - bit 3 selects RMII clock role: 0 master, 1 follower.
// - negotiation strap bits 2 and 1 reset to 1, derive advertised abilities.
// - bit 0 is inverse of negotiation-disable strap, resets to 1.
// - second lamp polarity bit 6 strap-loaded, resets 1, 1 is active high.
// - first lamp polarity bit 2 strap-loaded, resets 0, 0 is active low.
// - drive-enable set makes lamp show software drive value, not its event.
// - decoded register resets 0287h, snapshot 0000h, until straps are captured.
module plc_config_regs (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [plc_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	input  wire logic                         wvalid,
	output logic                              wready,
	output logic [1:0]                        bresp,
	output logic                              bvalid,
	input  wire logic                         bready,
	input  wire logic [plc_pkg::ADDR_W-1:0]   araddr,
	input  wire logic                         arvalid,
	output logic                              arready,
	output logic [31:0]                       rdata,
	output logic [1:0]                        rresp,
	output logic                              rvalid,
	input  wire logic                         rready,
	input  wire logic [plc_pkg::NUM_STRAPS-1:0] strap_pins,
	input  wire logic                         basic_mode_pin,
	input  wire logic [1:0]                   lamp_event,
	output logic                              mac_isolate,
	output logic                              receive_valid_pin_meaning,
	output logic [4:0]                        third_control_fld,
	output logic                              auto_crossover_enable,
	output logic                              rmii_mode,
	output logic                              reference_clock_follower,
	output logic [3:0]                        advertise_ability,
	output logic                              negotiation_enable,
	output logic                              slew_slow,
	output logic [1:0]                        lamp_out
);
	// ==========================================================
	// storage
	// ==========================================================
	logic [15:0]                slew_ctl;
	logic [15:0]                snapshot;
	logic [15:0]                decoded;
	logic [15:0]                led_ctl;
	logic [15:0]                wake_cfg;
	logic [plc_pkg::NUM_STRAPS-1:0] strap_level;
	logic                       capture;
	logic                       captured;
	logic                       basic_meta;
	logic                       basic_mode;
	// ==========================================================
	// write channel
	// ==========================================================
	plc_pkg::plc_wr_state_t     wr_state;
	logic                       aw_held;
	logic                       w_held;
	logic [10:0]                wr_idx;
	logic [31:0]                wr_data;
	logic [3:0]                 wr_strb;
	logic                       wr_fire;
	logic                       wr_hit;
	assign wr_fire = (wr_state == plc_pkg::PLC_WR_IDLE) && aw_held && w_held;
	assign wr_hit  = wr_idx == plc_pkg::IDX_SLEW || wr_idx == plc_pkg::IDX_SNAP
		|| wr_idx == plc_pkg::IDX_DEC || wr_idx == plc_pkg::IDX_LED
		|| wr_idx == plc_pkg::IDX_WAKE;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state <= plc_pkg::PLC_WR_IDLE;
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			awready  <= 1'b1;
			wready   <= 1'b1;
			bvalid   <= 1'b0;
			bresp    <= plc_pkg::RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				wr_idx  <= awaddr[plc_pkg::ADDR_W-1:2];
			end
			if (wvalid && wready)
			begin
				w_held  <= 1'b1;
				wready  <= 1'b0;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			case (wr_state)
				plc_pkg::PLC_WR_IDLE:
					if (wr_fire)
					begin
						bvalid   <= 1'b1;
						bresp    <= wr_hit ? plc_pkg::RESP_OKAY
							: plc_pkg::RESP_SLVERR;
						wr_state <= plc_pkg::PLC_WR_RESP;
					end
				plc_pkg::PLC_WR_RESP:
					if (bready)
					begin
						bvalid   <= 1'b0;
						aw_held  <= 1'b0;
						w_held   <= 1'b0;
						awready  <= 1'b1;
						wready   <= 1'b1;
						wr_state <= plc_pkg::PLC_WR_IDLE;
					end
				default:
					wr_state <= plc_pkg::PLC_WR_IDLE;
			endcase
		end
	end
	// ==========================================================
	// read channel
	// ==========================================================
	logic [10:0] rd_idx;
	logic [15:0] rd_val;
	logic        rd_hit;
	assign rd_idx = araddr[plc_pkg::ADDR_W-1:2];
	always_comb
	begin
		rd_hit = 1'b1;
		case (rd_idx)
			plc_pkg::IDX_SLEW: rd_val = slew_ctl;
			plc_pkg::IDX_SNAP: rd_val = snapshot;
			plc_pkg::IDX_DEC:  rd_val = decoded;
			plc_pkg::IDX_LED:  rd_val = led_ctl;
			plc_pkg::IDX_WAKE: rd_val = wake_cfg;
			default:
			begin
				rd_val = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= plc_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {16'h0000, rd_val};
			rresp   <= rd_hit ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end
	// ==========================================================
	// software registers
	// ==========================================================
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			slew_ctl <= plc_pkg::RST_SLEW;
		else if (wr_fire && wr_idx == plc_pkg::IDX_SLEW)
			slew_ctl <= plc_pkg::plc_merge(slew_ctl, wr_data, wr_strb,
				plc_pkg::WMASK_SLEW);
	end
	// bit 11 of the wake register is write-to-clear and never stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wake_cfg <= plc_pkg::RST_WAKE;
		else if (wr_fire && wr_idx == plc_pkg::IDX_WAKE)
			wake_cfg <= plc_pkg::plc_merge(wake_cfg, wr_data, wr_strb,
				plc_pkg::WMASK_WAKE);
	end
	// strap capture overrides a write landing in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			led_ctl <= plc_pkg::RST_LED;
		else if (capture)
		begin
			led_ctl[plc_pkg::LED2_POL] <= strap_level[plc_pkg::STRAP_LAMP2_POL];
			led_ctl[plc_pkg::LED1_POL] <= strap_level[plc_pkg::STRAP_LAMP1_POL];
		end
		else if (wr_fire && wr_idx == plc_pkg::IDX_LED)
			led_ctl <= plc_pkg::plc_merge(led_ctl, wr_data, wr_strb,
				plc_pkg::WMASK_LED);
	end
	// ==========================================================
	// strap capture and decode
	// ==========================================================
	plc_strap_capture #(
		.N (plc_pkg::NUM_STRAPS)
	) u_capture (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.strap_pins  (strap_pins),
		.strap_level (strap_level),
		.capture     (capture),
		.captured    (captured)
	);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			snapshot <= plc_pkg::RST_SNAP;
			decoded  <= plc_pkg::RST_DEC;
		end
		else if (capture)
		begin
			snapshot <= {5'h00, strap_level};
			decoded  <= plc_pkg::RST_DEC;
			decoded[plc_pkg::DEC_ISO]    <= strap_level[plc_pkg::STRAP_ISO];
			decoded[plc_pkg::DEC_RXV]    <= strap_level[plc_pkg::STRAP_RXV];
			decoded[plc_pkg::DEC_FLD]    <= strap_level[plc_pkg::STRAP_FLD];
			decoded[plc_pkg::DEC_AMDIX]  <=
				~strap_level[plc_pkg::STRAP_AUTO_CROSSOVER_DISABLE_STRAP];
			decoded[plc_pkg::DEC_RMII]   <= strap_level[plc_pkg::STRAP_RMII];
			decoded[plc_pkg::DEC_FOLLOW] <= strap_level[plc_pkg::STRAP_FOLLOW];
			decoded[plc_pkg::DEC_AN1]    <= strap_level[plc_pkg::STRAP_AN1];
			decoded[plc_pkg::DEC_AN0]    <= strap_level[plc_pkg::STRAP_AN0];
			decoded[plc_pkg::DEC_ANEN]   <=
				~strap_level[plc_pkg::STRAP_NEGOTIATION_DISABLE_STRAP];
		end
	end
	always_ff @(posedge aclk)
	begin
		basic_meta <= basic_mode_pin;
		basic_mode <= basic_meta;
	end
	// ==========================================================
	// configuration outputs
	// ==========================================================
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mac_isolate               <= 1'b0;
			receive_valid_pin_meaning <= 1'b0;
			third_control_fld         <= plc_pkg::FLD_OFF;
			auto_crossover_enable     <= 1'b1;
			rmii_mode                 <= 1'b0;
			reference_clock_follower  <= 1'b0;
			advertise_ability         <= 4'hF;
			negotiation_enable        <= 1'b1;
			slew_slow                 <= 1'b0;
		end
		else
		begin
			mac_isolate <= basic_mode && decoded[plc_pkg::DEC_ISO];
			receive_valid_pin_meaning <= decoded[plc_pkg::DEC_RMII]
				&& decoded[plc_pkg::DEC_RXV];
			third_control_fld <= decoded[plc_pkg::DEC_FLD]
				? plc_pkg::FLD_ON : plc_pkg::FLD_OFF;
			auto_crossover_enable    <= decoded[plc_pkg::DEC_AMDIX];
			rmii_mode                <= decoded[plc_pkg::DEC_RMII];
			reference_clock_follower <= decoded[plc_pkg::DEC_FOLLOW];
			advertise_ability <= plc_pkg::plc_advert(
				decoded[plc_pkg::DEC_AN1], decoded[plc_pkg::DEC_AN0]);
			negotiation_enable <= decoded[plc_pkg::DEC_ANEN];
			slew_slow <= slew_ctl[plc_pkg::SLEW_BIT];
		end
	end
	// ==========================================================
	// lamps
	// ==========================================================
	plc_pkg::plc_lamp_ctl_t lamp1_ctl;
	plc_pkg::plc_lamp_ctl_t lamp2_ctl;
	assign lamp1_ctl = {led_ctl[plc_pkg::LED1_POL], led_ctl[plc_pkg::LED1_VAL],
		led_ctl[plc_pkg::LED1_EN]};
	assign lamp2_ctl = {led_ctl[plc_pkg::LED2_POL], led_ctl[plc_pkg::LED2_VAL],
		led_ctl[plc_pkg::LED2_EN]};
	plc_lamp_driver u_lamp1 (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ctl      (lamp1_ctl),
		.event_in (lamp_event[0]),
		.lamp     (lamp_out[0])
	);
	plc_lamp_driver u_lamp2 (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ctl      (lamp2_ctl),
		.event_in (lamp_event[1]),
		.lamp     (lamp_out[1])
	);
	// ==========================================================
	// assertions
	// ==========================================================
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_slew;
		wr_fire && wr_idx == plc_pkg::IDX_SLEW && wr_strb[0]
			|=> ##1 slew_slow == $past(wr_data[0], 2);
	endproperty
	a_slew: assert property (p_slew)
		else $error("slew output not following write");
	property p_snapshot;
		capture |=> snapshot[10:0] == $past(strap_level);
	endproperty
	a_snapshot: assert property (p_snapshot)
		else $error("snapshot mismatch");
	property p_isolate;
		##1 mac_isolate == $past(basic_mode && decoded[plc_pkg::DEC_ISO]);
	endproperty
	a_isolate: assert property (p_isolate)
		else $error("isolation output wrong");
	property p_rxvalid;
		##1 receive_valid_pin_meaning == $past(decoded[plc_pkg::DEC_RMII]
			&& decoded[plc_pkg::DEC_RXV]);
	endproperty
	a_rxvalid: assert property (p_rxvalid)
		else $error("receive-valid meaning wrong");
	property p_fld;
		capture |=> ##1 third_control_fld == ($past(
			strap_level[plc_pkg::STRAP_FLD], 2) ? 5'h1A : 5'h00);
	endproperty
	a_fld: assert property (p_fld)
		else $error("fast link-down value wrong");
	property p_inverse;
		capture |=> decoded[plc_pkg::DEC_AMDIX]
			!= $past(strap_level[plc_pkg::STRAP_AUTO_CROSSOVER_DISABLE_STRAP])
			&& decoded[plc_pkg::DEC_ANEN]
			!= $past(strap_level[plc_pkg::STRAP_NEGOTIATION_DISABLE_STRAP]);
	endproperty
	a_inverse: assert property (p_inverse)
		else $error("inverted strap bits wrong");
	property p_lamp_pol;
		capture |=> led_ctl[6] == $past(strap_level[9])
			&& led_ctl[2] == $past(strap_level[10]);
	endproperty
	a_lamp_pol: assert property (p_lamp_pol)
		else $error("lamp polarity not strap-loaded");
	property p_precapture;
		!captured |-> snapshot == 16'h0000 && decoded == 16'h0287;
	endproperty
	a_precapture: assert property (p_precapture)
		else $error("pre-capture value wrong");
	property p_reserved;
		led_ctl[15:11] == 5'h00 && wake_cfg[11] == 1'b0 && decoded[9] == 1'b1;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bit changed");
	c_write: cover property (wr_fire ##1 bvalid && bready);
	c_read: cover property (arvalid && arready ##1 rvalid && rready);
	c_capture: cover property (capture ##1 decoded[plc_pkg::DEC_FLD]);
endmodule

// >>> plc_pkg.sv
package plc_pkg;

	// ==========================================================
	// bus and register map
	// ==========================================================
	localparam int          ADDR_W      = 13;
	localparam logic [10:0] IDX_SLEW    = 11'h461;
	localparam logic [10:0] IDX_SNAP    = 11'h467;
	localparam logic [10:0] IDX_DEC     = 11'h468;
	localparam logic [10:0] IDX_LED     = 11'h469;
	localparam logic [10:0] IDX_WAKE    = 11'h4A0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ==========================================================
	// reset values and writable masks
	// ==========================================================
	localparam logic [15:0] RST_SLEW   = 16'h0010;
	localparam logic [15:0] RST_SNAP   = 16'h0000;
	localparam logic [15:0] RST_DEC    = 16'h0287;
	localparam logic [15:0] RST_LED    = 16'h0440;
	localparam logic [15:0] RST_WAKE   = 16'h1081;
	localparam logic [15:0] WMASK_SLEW = 16'hFFFF;
	localparam logic [15:0] WMASK_LED  = 16'h0777;
	localparam logic [15:0] WMASK_WAKE = 16'h17E1;

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int SLEW_BIT   = 0;
	localparam int DEC_ISO    = 14;
	localparam int DEC_RXV    = 12;
	localparam int DEC_FLD    = 8;
	localparam int DEC_AMDIX  = 7;
	localparam int DEC_RMII   = 4;
	localparam int DEC_FOLLOW = 3;
	localparam int DEC_AN1    = 2;
	localparam int DEC_AN0    = 1;
	localparam int DEC_ANEN   = 0;
	localparam int LED2_POL   = 6;
	localparam int LED2_VAL   = 5;
	localparam int LED2_EN    = 4;
	localparam int LED1_POL   = 2;
	localparam int LED1_VAL   = 1;
	localparam int LED1_EN    = 0;

	// ==========================================================
	// strap pin assignment and timing
	// ==========================================================
	localparam int NUM_STRAPS      = 11;
	localparam int STRAP_ISO       = 0;
	localparam int STRAP_RXV       = 1;
	localparam int STRAP_FLD       = 2;
	localparam int STRAP_AUTO_CROSSOVER_DISABLE_STRAP = 3;
	localparam int STRAP_RMII      = 4;
	localparam int STRAP_FOLLOW    = 5;
	localparam int STRAP_AN1       = 6;
	localparam int STRAP_AN0       = 7;
	localparam int STRAP_NEGOTIATION_DISABLE_STRAP  = 8;
	localparam int STRAP_LAMP2_POL = 9;
	localparam int STRAP_LAMP1_POL = 10;
	localparam logic [1:0] CAPTURE_WAIT = 2'h3;
	localparam logic [4:0] FLD_ON       = 5'h1A;
	localparam logic [4:0] FLD_OFF      = 5'h00;

	// ==========================================================
	// types
	// ==========================================================
	typedef enum logic [1:0]
	{
		PLC_WR_IDLE = 2'b01,
		PLC_WR_RESP = 2'b10
	} plc_wr_state_t;

	typedef struct packed
	{
		logic polarity;
		logic force_value;
		logic force_enable;
	} plc_lamp_ctl_t;

	// ==========================================================
	// helpers
	// ==========================================================
	function automatic logic [15:0] plc_merge(
		input logic [15:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  wstrb,
		input logic [15:0] wmask
	);
		logic [15:0] lanes;
		lanes = {{8{wstrb[1]}}, {8{wstrb[0]}}} & wmask;
		return (old_val & ~lanes) | (wdata[15:0] & lanes);
	endfunction

	// ability bits 8:5 are 100 full, 100 half, 10 full, 10 half
	function automatic logic [3:0] plc_advert(
		input logic an1,
		input logic an0
	);
		case ({an1, an0})
			2'h0:    return 4'h3;
			2'h1:    return 4'hC;
			2'h2:    return 4'h5;
			default: return 4'hF;
		endcase
	endfunction

endpackage

// >>> plc_strap_capture.sv
`timescale 1ns/10ps
module plc_strap_capture #(
	parameter int N = 11
)(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] strap_pins,
	output logic      [N-1:0] strap_level,
	output logic              capture,
	output logic              captured
);

	// ==========================================================
	// synchroniser and one-shot capture after reset release
	// ==========================================================
	logic [N-1:0] meta;
	logic [1:0]   wait_cnt;

	always_ff @(posedge aclk)
	begin
		meta        <= strap_pins;
		strap_level <= meta;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wait_cnt <= 2'h0;
			capture  <= 1'b0;
			captured <= 1'b0;
		end
		else
		begin
			capture <= 1'b0;
			if (!captured && wait_cnt == plc_pkg::CAPTURE_WAIT)
			begin
				capture  <= 1'b1;
				captured <= 1'b1;
			end
			else if (!captured)
				wait_cnt <= wait_cnt + 2'h1;
		end
	end

endmodule

// >>> plc_lamp_driver.sv
`timescale 1ns/10ps
module plc_lamp_driver (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire plc_pkg::plc_lamp_ctl_t ctl,
	input  wire logic                  event_in,
	output logic                       lamp
);

	// ==========================================================
	// override then polarity; active low inverts the pin
	// ==========================================================
	logic lit;
	assign lit = ctl.force_enable ? ctl.force_value : event_in;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			lamp <= 1'b0;
		else
			lamp <= ctl.polarity ? lit : ~lit;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_lamp_force;
		ctl.force_enable |=> lamp == ($past(ctl.force_value)
			~^ $past(ctl.polarity));
	endproperty
	a_lamp_force: assert property (p_lamp_force)
		else $error("forced lamp level wrong");

	property p_lamp_event;
		!ctl.force_enable |=> lamp == ($past(event_in)
			^ ~$past(ctl.polarity));
	endproperty
	a_lamp_event: assert property (p_lamp_event)
		else $error("lamp does not follow event");

endmodule

// >>> test_phy_strap_io_led_config.sv
`timescale 1ns/10ps
module test_phy_strap_io_led_config;

	// ==========================================================
	// signals
	// ==========================================================
	logic                         aclk;
	logic                         aresetn;
	logic [plc_pkg::ADDR_W-1:0]   awaddr;
	logic [plc_pkg::ADDR_W-1:0]   araddr;
	logic                         awvalid;
	logic                         awready;
	logic                         wvalid;
	logic                         wready;
	logic                         bvalid;
	logic                         bready;
	logic                         arvalid;
	logic                         arready;
	logic                         rvalid;
	logic                         rready;
	logic [31:0]                  wdata;
	logic [31:0]                  rdata;
	logic [31:0]                  rd_data;
	logic [3:0]                   wstrb;
	logic [1:0]                   bresp;
	logic [1:0]                   rresp;
	logic [1:0]                   rd_resp;
	logic [plc_pkg::NUM_STRAPS-1:0] strap_pins;
	logic                         basic_mode_pin;
	logic [1:0]                   lamp_event;
	logic                         mac_isolate;
	logic                         receive_valid_pin_meaning;
	logic [4:0]                   third_control_fld;
	logic                         auto_crossover_enable;
	logic                         rmii_mode;
	logic                         reference_clock_follower;
	logic [3:0]                   advertise_ability;
	logic                         negotiation_enable;
	logic                         slew_slow;
	logic [1:0]                   lamp_out;
	logic [14:0]                  side;
	int                           n_mismatch;
	int                           compares;

	assign side = {mac_isolate, receive_valid_pin_meaning, third_control_fld,
		auto_crossover_enable, rmii_mode, reference_clock_follower,
		advertise_ability, negotiation_enable};

	plc_config_regs u_plc_config_regs (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.strap_pins(strap_pins), .basic_mode_pin(basic_mode_pin),
		.lamp_event(lamp_event), .mac_isolate(mac_isolate),
		.receive_valid_pin_meaning(receive_valid_pin_meaning),
		.third_control_fld(third_control_fld),
		.auto_crossover_enable(auto_crossover_enable),
		.rmii_mode(rmii_mode),
		.reference_clock_follower(reference_clock_follower),
		.advertise_ability(advertise_ability),
		.negotiation_enable(negotiation_enable),
		.slew_slow(slew_slow), .lamp_out(lamp_out)
	);

	// ==========================================================
	// helpers
	// ==========================================================
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	function automatic logic lamp_pin(input logic [3:0] c);
		logic on;
		on = c[1] ? c[2] : c[0];
		return c[3] ? on : ~on;
	endfunction

	task automatic wr(input logic [10:0] idx, input logic [15:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic aw_d;
		logic w_d;
		logic b_d;
		int   n;
		aw_d = 1'b0;
		w_d = 1'b0;
		b_d = 1'b0;
		n = 0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_d && n < 64)
		begin
			@(posedge aclk);
			n++;
			if (!aw_d && awready)
			begin
				aw_d = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_d && wready)
			begin
				w_d = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid)
			begin
				b_d = 1'b1;
				bready <= 1'b0;
				check({30'h0, bresp}, {30'h0, er});
			end
		end
		check({31'h0, b_d}, 32'h1);
	endtask

	task automatic rd(input logic [10:0] idx, input logic [1:0] er);
		logic ar_d;
		logic r_d;
		int   n;
		ar_d = 1'b0;
		r_d = 1'b0;
		n = 0;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_d && n < 64)
		begin
			@(posedge aclk);
			n++;
			if (!ar_d && arready)
			begin
				ar_d = 1'b1;
				arvalid <= 1'b0;
			end
			if (rvalid)
			begin
				r_d = 1'b1;
				rd_data = rdata;
				rd_resp = rresp;
				rready <= 1'b0;
			end
		end
		check({31'h0, r_d}, 32'h1);
		check({30'h0, rd_resp}, {30'h0, er});
	endtask

	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_straps(input logic [10:0] p, input logic b,
		input logic [15:0] e_dec, input logic [15:0] e_led,
		input logic [14:0] e_side);
		@(posedge aclk);
		aresetn <= 1'b0;
		strap_pins <= p;
		basic_mode_pin <= b;
		lamp_event <= 2'h0;
		repeat (12) @(posedge aclk);
		check({17'h0, side}, {17'h0, 15'h009F});
		check({28'h0, slew_slow, lamp_out, bvalid | rvalid}, 32'h0);
		aresetn <= 1'b1;
		repeat (12) @(posedge aclk);
		rd(plc_pkg::IDX_SNAP, plc_pkg::RESP_OKAY);
		check(rd_data, {21'h0, p});
		rd(plc_pkg::IDX_DEC, plc_pkg::RESP_OKAY);
		check(rd_data, {16'h0, e_dec});
		rd(plc_pkg::IDX_LED, plc_pkg::RESP_OKAY);
		check(rd_data, {16'h0, e_led});
		check({17'h0, side}, {17'h0, e_side});
		check({30'h0, lamp_out}, {30'h0, ~e_led[6], ~e_led[2]});
		$display("test straps done");
	endtask

	task automatic t_slew();
		rd(plc_pkg::IDX_SLEW, plc_pkg::RESP_OKAY);
		check(rd_data, 32'h0010);
		wr(plc_pkg::IDX_SLEW, 16'h0011, 4'h1, plc_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		check({31'h0, slew_slow}, 32'h1);
		wr(plc_pkg::IDX_SLEW, 16'h0010, 4'h0, plc_pkg::RESP_OKAY);
		rd(plc_pkg::IDX_SLEW, plc_pkg::RESP_OKAY);
		check(rd_data, 32'h0011);
		wr(plc_pkg::IDX_SLEW, 16'h0010, 4'h3, plc_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		check({31'h0, slew_slow}, 32'h0);
		$display("test slew done");
	endtask

	task automatic t_ro();
		wr(plc_pkg::IDX_SNAP, 16'hFFFF, 4'h3, plc_pkg::RESP_OKAY);
		rd(plc_pkg::IDX_SNAP, plc_pkg::RESP_OKAY);
		check(rd_data, 32'h0577);
		wr(plc_pkg::IDX_DEC, 16'h0000, 4'h3, plc_pkg::RESP_OKAY);
		rd(plc_pkg::IDX_DEC, plc_pkg::RESP_OKAY);
		check(rd_data, 32'h539C);
		wr(11'h462, 16'hFFFF, 4'h3, plc_pkg::RESP_SLVERR);
		rd(11'h462, plc_pkg::RESP_SLVERR);
		check(rd_data, 32'h0);
		wr(plc_pkg::IDX_LED, 16'hFFFF, 4'h3, plc_pkg::RESP_OKAY);
		rd(plc_pkg::IDX_LED, plc_pkg::RESP_OKAY);
		check(rd_data, 32'h0777);
		rd(plc_pkg::IDX_WAKE, plc_pkg::RESP_OKAY);
		check(rd_data, 32'h1081);
		wr(plc_pkg::IDX_WAKE, 16'hFFFF, 4'h3, plc_pkg::RESP_OKAY);
		rd(plc_pkg::IDX_WAKE, plc_pkg::RESP_OKAY);
		check(rd_data, 32'h17E1);
		$display("test read-only done");
	endtask

	// lamp codes are {polarity, force value, force enable, event}
	task automatic t_lamp();
		logic [3:0] c1;
		logic [3:0] c2;
		for (int i = 0; i < 16; i++)
		begin
			c1 = i[3:0];
			c2 = ~c1;
			lamp_event <= {c2[0], c1[0]};
			wr(plc_pkg::IDX_LED, {9'h000, c2[3:1], 1'b0, c1[3:1]}, 4'h1,
				plc_pkg::RESP_OKAY);
			repeat (2) @(posedge aclk);
			check({30'h0, lamp_out}, {30'h0, lamp_pin(c2), lamp_pin(c1)});
		end
		$display("test lamp done");
	endtask

	// ==========================================================
	// clock, sequence and watchdog
	// ==========================================================
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	initial
	begin
		n_mismatch = 0;
		compares = 0;
		aresetn = 1'b0;
		awaddr = '0;
		araddr = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		strap_pins = '0;
		basic_mode_pin = 1'b0;
		lamp_event = 2'h0;
		t_straps(11'h577, 1'b1, 16'h539C, 16'h0404,
			{1'b1, 1'b1, 5'h1A, 1'b1, 1'b1, 1'b1, 4'h5, 1'b0});
		t_slew();
		t_ro();
		t_lamp();
		t_straps(11'h288, 1'b0, 16'h0203, 16'h0440,
			{1'b0, 1'b0, 5'h00, 1'b0, 1'b0, 1'b0, 4'hC, 1'b1});
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		stop_test();
	end

endmodule
